// File: core/clk_pkg.sv
// Register map, field layout and constants for the clock output block
package clk_pkg;
	localparam logic [7:0] TRIM_ADDR = 8'h3c;
	localparam logic [7:0] SYNTH_CTRL_ADDR = 8'h3d;
	localparam logic [7:0] STATUS_ADDR = 8'h60;
	localparam logic [7:0] SYNTH_CTRL_RST = 8'h00;
	localparam logic [7:0] TRIM_RST = 8'h80;
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 4;
	localparam int EN_BIT = 3;
	localparam int PD_BIT = 2;
	localparam int FB_MSB = 1;
	localparam int FB_LSB = 0;
	localparam logic [3:0] SEL_IO = 4'h0;
	localparam logic [3:0] SEL_SYNTH = 4'h1;
	localparam logic [3:0] SEL_LOW = 4'h2;
	localparam logic [3:0] SEL_HIGH = 4'h3;
	localparam logic [3:0] SEL_XTAL = 4'h4;
	localparam logic [3:0] SEL_DIV2 = 4'h5;
	localparam logic [3:0] SEL_DIV4 = 4'h6;
	localparam logic [3:0] SEL_DIV8 = 4'h7;
	localparam logic [1:0] SEL_GRP_TIMER = 2'h2;
	localparam logic [1:0] SEL_GRP_RSVD = 2'h3;
	localparam logic [4:0] FB_RATIO_A = 5'h17;
	localparam logic [4:0] FB_RATIO_B = 5'h1b;
	localparam logic [4:0] FB_RATIO_C = 5'h1c;
	localparam logic [19:0] XTAL_KHZ = 20'h069f0;
	localparam logic [7:0] OUT_DIV_MIN = 8'h08;

	function automatic logic [4:0] fb_ratio(input logic [1:0] code);
		case (code)
			2'h1: fb_ratio = FB_RATIO_B;
			2'h2: fb_ratio = FB_RATIO_C;
			default: fb_ratio = FB_RATIO_A;
		endcase
	endfunction
endpackage

// File: core/synth_if.sv
// Control and status bundle between register logic and synthesizer control
`timescale 1ns/1ps
interface synth_if;
	logic [1:0] fb_code;
	logic pd;
	logic [7:0] out_div;
	logic [4:0] ratio;
	logic [15:0] khz;
	modport ctrl(output fb_code, output pd, output out_div, input ratio, input khz);
	modport synth(input fb_code, input pd, input out_div, output ratio, output khz);
endinterface

// File: core/xtal_divider.sv
// Crystal clock divider giving the /2, /4 and /8 levels
`timescale 1ns/1ps
module xtal_divider (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic xtal_lvl,
	output logic [2:0] div_lvl
);
	import clk_pkg::*;
	logic xtal_prev_q;
	logic [2:0] cnt_q;
	logic xtal_rise;

	assign xtal_rise = xtal_lvl & ~xtal_prev_q;
	assign div_lvl = cnt_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			xtal_prev_q <= 1'b0;
			cnt_q <= 3'h0;
		end else begin
			xtal_prev_q <= xtal_lvl;
			if (xtal_rise) begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end

	AST_DIV2_TOGGLE: assert property (@(posedge mclk) disable iff (!rst_n)
		xtal_rise |=> div_lvl[0] != $past(div_lvl[0]))
		else $error("div2 missed a crystal edge");
	AST_DIV4_PACE: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(div_lvl[1]) |-> $past(div_lvl[0]) && !div_lvl[0])
		else $error("div4 changed out of step");
endmodule

// File: core/synth_control.sv
// Feedback ratio decode and nominal synthesizer output frequency
`timescale 1ns/1ps
module synth_control (
	input wire logic mclk,
	input wire logic rst_n,
	synth_if.synth sif
);
	import clk_pkg::*;
	logic [4:0] ratio_d;
	logic [4:0] ratio_q;
	logic [19:0] vco_half_khz;
	logic [15:0] khz_d;
	logic [15:0] khz_q;

	assign ratio_d = fb_ratio(sif.fb_code);
	// First stage: reference times ratio, halved; second stage: output divider
	assign vco_half_khz = 20'((25'(XTAL_KHZ) * 25'(ratio_d)) >> 1);
	// Dividers below the minimum are reserved; report no output then
	assign khz_d = (sif.pd || sif.out_div < OUT_DIV_MIN) ? 16'h0000 :
		16'(vco_half_khz / 20'(sif.out_div));
	assign sif.ratio = ratio_q;
	assign sif.khz = khz_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ratio_q <= FB_RATIO_A;
			khz_q <= 16'h0000;
		end else begin
			ratio_q <= ratio_d;
			khz_q <= khz_d;
		end
	end

	AST_FB_CODE3: assert property (@(posedge mclk) disable iff (!rst_n)
		sif.fb_code == 2'h3 |=> sif.ratio == 5'h17)
		else $error("code 3 must give ratio 23");
	AST_FB_CODE1: assert property (@(posedge mclk) disable iff (!rst_n)
		sif.fb_code == 2'h1 |=> sif.ratio == 5'h1b)
		else $error("code 1 must give ratio 27");
	AST_FREQ_28_8: assert property (@(posedge mclk) disable iff (!rst_n)
		!sif.pd && sif.fb_code == 2'h2 && sif.out_div == 8'h08 |=> sif.khz == 16'hb964)
		else $error("two-stage frequency wrong");
	AST_PD_NO_FREQ: assert property (@(posedge mclk) disable iff (!rst_n)
		sif.pd |=> sif.khz == 16'h0000)
		else $error("powered-down synth reports output");
endmodule

// File: core/pll_clock_output_control.sv
// Synthesizer control, slow oscillator trim and clock output pin source selection
// Behaviour
// - Select 0h releases the clock output pin for general input/output use.
// - Select 1h routes the synthesizer output to the clock output pin.
// - Select 2h holds the pin low and select 3h holds it high.
// - Select 4h shows the undivided 27.12 MHz crystal clock on the pin.
// - Selects 5h, 6h and 7h show the crystal clock divided by 2, 4 and 8.
// - Selects 8h to Bh invert the pin on each overflow of timer 0 to 3.
// - A clock is driven on the pin only while the output enable bit 3 is set.
// - Feedback code 00, 01, 10, 11 selects ratio 23, 27, 28, 23.
// - Synthesizer output is reference times ratio, halved, then divided by the output divider.
// - The 8-bit slow oscillator trim acts inversely: a higher code gives a lower frequency.
`timescale 1ns/1ps
module pll_clock_output_control (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic xtal_level,
	input wire logic synth_clk_level,
	input wire logic [7:0] synth_output_divider,
	input wire logic [3:0] timer_overflow,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	output logic gpio_in,
	input wire logic clock_output_pin_i,
	output logic clock_output_pin_o,
	output logic clock_output_pin_oe,
	output logic synth_power_down,
	output logic [4:0] synth_feedback_ratio,
	output logic [15:0] synth_freq_khz,
	output logic [7:0] slow_osc_trim_value
);
	import clk_pkg::*;

	logic [7:0] ctrl_q;
	logic [7:0] trim_q;
	logic [7:0] rdata_q;
	logic xtal_q;
	logic synth_lvl_q;
	logic tog_q;
	logic pin_o_q;
	logic pin_oe_q;
	logic gpio_in_q;
	logic pd_q;
	logic [2:0] div_lvl;

	logic [3:0] out_pin_source_select;
	logic out_pin_enable;
	logic ctrl_pd;
	logic wr_ctrl;
	logic wr_trim;
	logic synth_gated;
	logic timer_hit;
	logic is_timer_sel;
	logic src_level;
	logic pin_o_d;
	logic pin_oe_d;
	logic [7:0] rd_mux;
	logic [7:0] status_word;

	synth_if sif();

	xtal_divider u_div (
		.mclk(mclk),
		.rst_n(rst_n),
		.xtal_lvl(xtal_q),
		.div_lvl(div_lvl)
	);

	synth_control u_synth (
		.mclk(mclk),
		.rst_n(rst_n),
		.sif(sif.synth)
	);

	assign out_pin_source_select = ctrl_q[SEL_MSB:SEL_LSB];
	assign out_pin_enable = ctrl_q[EN_BIT];
	assign ctrl_pd = ctrl_q[PD_BIT];
	assign sif.fb_code = ctrl_q[FB_MSB:FB_LSB];
	assign sif.pd = ctrl_pd;
	assign sif.out_div = synth_output_divider;

	assign wr_ctrl = reg_wr && reg_addr == SYNTH_CTRL_ADDR;
	assign wr_trim = reg_wr && reg_addr == TRIM_ADDR;

	// Powered-down synthesizer contributes a steady low, not a stale clock
	assign synth_gated = synth_lvl_q & ~ctrl_pd;
	assign is_timer_sel = out_pin_source_select[3:2] == SEL_GRP_TIMER;
	assign timer_hit = is_timer_sel && timer_overflow[out_pin_source_select[1:0]];

	// Reserved selects fall through to the final low
	assign src_level = (out_pin_source_select == SEL_SYNTH) ? synth_gated :
		(out_pin_source_select == SEL_LOW) ? 1'b0 :
		(out_pin_source_select == SEL_HIGH) ? 1'b1 :
		(out_pin_source_select == SEL_XTAL) ? xtal_q :
		(out_pin_source_select == SEL_DIV2) ? div_lvl[0] :
		(out_pin_source_select == SEL_DIV4) ? div_lvl[1] :
		(out_pin_source_select == SEL_DIV8) ? div_lvl[2] :
		is_timer_sel ? tog_q : 1'b0;

	assign pin_o_d = (out_pin_source_select == SEL_IO) ? gpio_out : (out_pin_enable & src_level);
	assign pin_oe_d = (out_pin_source_select == SEL_IO) ? gpio_oe : out_pin_enable;

	assign status_word = {5'h00, tog_q, pin_oe_q, pin_o_q};
	assign rd_mux = (reg_addr == SYNTH_CTRL_ADDR) ? ctrl_q :
		(reg_addr == TRIM_ADDR) ? trim_q :
		(reg_addr == STATUS_ADDR) ? status_word : 8'h00;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_q <= SYNTH_CTRL_RST;
			trim_q <= TRIM_RST;
			rdata_q <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata;
			end
			if (wr_trim) begin
				trim_q <= reg_wdata;
			end
			rdata_q <= reg_rd ? rd_mux : 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			xtal_q <= 1'b0;
			synth_lvl_q <= 1'b0;
			tog_q <= 1'b0;
		end else begin
			xtal_q <= xtal_level;
			synth_lvl_q <= synth_clk_level;
			tog_q <= tog_q ^ timer_hit;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pin_o_q <= 1'b0;
			pin_oe_q <= 1'b0;
			gpio_in_q <= 1'b0;
			pd_q <= 1'b0;
		end else begin
			pin_o_q <= pin_o_d;
			pin_oe_q <= pin_oe_d;
			gpio_in_q <= clock_output_pin_i;
			pd_q <= ctrl_pd;
		end
	end

	assign reg_rdata = rdata_q;
	assign clock_output_pin_o = pin_o_q;
	assign clock_output_pin_oe = pin_oe_q;
	assign gpio_in = gpio_in_q;
	assign synth_power_down = pd_q;
	assign synth_feedback_ratio = sif.ratio;
	assign synth_freq_khz = sif.khz;
	// Analog oscillator takes the code as is; its slope is inverse by design
	assign slow_osc_trim_value = trim_q;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence held_sel(logic [3:0] s);
		out_pin_enable && out_pin_source_select == s;
	endsequence

	AST_IO_RELEASE: assert property (
		out_pin_source_select == SEL_IO |=> clock_output_pin_oe == $past(gpio_oe))
		else $error("pin not handed to gpio");
	AST_SYNTH_ROUTE: assert property (
		held_sel(SEL_SYNTH) ##1 held_sel(SEL_SYNTH) ##0 !ctrl_pd |=> clock_output_pin_o == $past(synth_clk_level, 2))
		else $error("synth level not on pin");
	AST_HOLD_LOW: assert property (
		held_sel(SEL_LOW) |=> clock_output_pin_oe && !clock_output_pin_o)
		else $error("pin not held low");
	AST_HOLD_HIGH: assert property (
		held_sel(SEL_HIGH) |=> clock_output_pin_oe && clock_output_pin_o)
		else $error("pin not held high");
	AST_XTAL_ROUTE: assert property (
		held_sel(SEL_XTAL) ##1 held_sel(SEL_XTAL) |=> clock_output_pin_o == $past(xtal_level, 2))
		else $error("crystal not on pin");
	AST_DIV8_ROUTE: assert property (
		held_sel(SEL_DIV8) |=> clock_output_pin_o == $past(div_lvl[2]))
		else $error("div8 not on pin");
	// Select and enable must hold across both steps, or the pin may not toggle
	AST_TIMER_TOGGLE: assert property (
		out_pin_enable && timer_hit ##1 out_pin_enable && $stable(out_pin_source_select)
		|=> clock_output_pin_o != $past(clock_output_pin_o))
		else $error("pin did not toggle on overflow");
	AST_RESERVED_LOW: assert property (
		out_pin_enable && out_pin_source_select[3:2] == SEL_GRP_RSVD |=> !clock_output_pin_o)
		else $error("reserved select not low");
	AST_DISABLED_QUIET: assert property (
		!out_pin_enable && out_pin_source_select != SEL_IO |=> !clock_output_pin_oe && !clock_output_pin_o)
		else $error("clock driven while disabled");
	AST_PD_NO_SYNTH: assert property (
		held_sel(SEL_SYNTH) ##0 ctrl_pd |=> !clock_output_pin_o && synth_power_down)
		else $error("powered-down synth reached pin");
	AST_TRIM_WRITE: assert property (
		wr_trim |=> slow_osc_trim_value == $past(reg_wdata))
		else $error("trim write lost");
endmodule

// File: bench/tb_pll_clock_output_control.sv
// Self-checking bench for the clock output control block
`timescale 1ns/1ps
module tb_pll_clock_output_control;
	import clk_pkg::*;
	logic mclk, rst_n, reg_wr, reg_rd, xtal_level, synth_clk_level, gpio_out, gpio_oe, clock_output_pin_i;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, synth_output_divider, slow_osc_trim_value, v;
	logic [3:0] timer_overflow;
	logic gpio_in, clock_output_pin_o, clock_output_pin_oe, synth_power_down;
	logic rd_pend, s1, s2, lag_on, use_x, pin_prev, p;
	logic [4:0] synth_feedback_ratio;
	logic [15:0] synth_freq_khz;
	logic [7:0] exp_q[$];
	int n_mismatch = 0, comparisons = 0, cycles = 0, seed = 32'hf4dd, edges = 0, r, ex;
	pll_clock_output_control i_dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.xtal_level, .synth_clk_level, .synth_output_divider, .timer_overflow, .gpio_out, .gpio_oe, .gpio_in,
		.clock_output_pin_i, .clock_output_pin_o, .clock_output_pin_oe, .synth_power_down,
		.synth_feedback_ratio, .synth_freq_khz, .slow_osc_trim_value);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(exp);
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask
	task automatic pulse(input logic [3:0] m);
		@(posedge mclk);
		timer_overflow <= m;
		@(posedge mclk);
		timer_overflow <= 4'h0;
		cyc(3);
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Result watcher: read data stand only in the cycle after the strobe
	always @(posedge mclk) begin
		cycles++;
		if (rd_pend)
			chk(reg_rdata, exp_q.pop_front());
		rd_pend <= reg_rd;
		s1 <= use_x ? xtal_level : synth_clk_level;
		s2 <= s1;
		xtal_level <= ~xtal_level;
		synth_clk_level <= 1'($random(seed));
		if (cycles == 6000) begin
			n_mismatch++;
			give_verdict;
		end
	end
	always @(negedge mclk) begin
		if (lag_on)
			chk(clock_output_pin_o, s2);
		if (clock_output_pin_o && !pin_prev)
			edges++;
		pin_prev = clock_output_pin_o;
	end
	initial begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, xtal_level, synth_clk_level} = '0;
		{gpio_out, gpio_oe, clock_output_pin_i, timer_overflow, rd_pend, lag_on, pin_prev} = '0;
		synth_output_divider = 8'h08;
		use_x = 1'b1;
		cyc(3);
		rst_n <= 1'b1;
		rd(TRIM_ADDR, TRIM_RST);
		rd(SYNTH_CTRL_ADDR, SYNTH_CTRL_RST);
		rd(8'h55, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(SYNTH_CTRL_ADDR, {4'h2, 2'b10, c[1:0]});
			rd(SYNTH_CTRL_ADDR, {4'h2, 2'b10, c[1:0]});
			synth_output_divider <= (c == 3) ? 8'h0a : 8'h08;
			cyc(4);
			r = (c == 2) ? 28 : (c == 1) ? 27 : 23;
			chk(16'(synth_feedback_ratio), 16'(r));
			chk(synth_freq_khz, 16'(27120 * r / (2 * ((c == 3) ? 10 : 8))));
		end
		synth_output_divider <= 8'h07;
		cyc(4);
		chk(synth_freq_khz, 16'h0000);
		synth_output_divider <= 8'h08;
		wr(SYNTH_CTRL_ADDR, 8'h1c);
		cyc(4);
		chk(16'(synth_power_down), 16'h0001);
		chk(synth_freq_khz, 16'h0000);
		repeat (4) @(negedge mclk) chk(16'(clock_output_pin_o), 16'h0000);
		use_x = 1'b0;
		wr(SYNTH_CTRL_ADDR, 8'h18);
		cyc(3);
		lag_on = 1'b1;
		cyc(16);
		lag_on = 1'b0;
		use_x = 1'b1;
		wr(SYNTH_CTRL_ADDR, 8'h48);
		cyc(3);
		lag_on = 1'b1;
		cyc(16);
		lag_on = 1'b0;
		// Crystal toggles every cycle, so 64 cycles hold 32 rising edges
		for (int k = 4; k < 8; k++) begin
			wr(SYNTH_CTRL_ADDR, {4'(k), 4'h8});
			cyc(6);
			edges = 0;
			cyc(64);
			ex = 32 >> (k - 4);
			chk(16'(edges >= ex - 1 && edges <= ex + 1), 16'h0001);
		end
		wr(SYNTH_CTRL_ADDR, 8'h40);
		cyc(4);
		edges = 0;
		cyc(16);
		chk(16'(edges), 16'h0000);
		for (int s = 2; s < 16; s++)
			if (s < 4 || s > 11)
				for (int en = 0; en < 2; en++) begin
					wr(SYNTH_CTRL_ADDR, {4'(s), en[0], 3'h0});
					cyc(3);
					chk(16'(clock_output_pin_oe), 16'(en));
					chk(16'(clock_output_pin_o), 16'(s == 3 && en == 1));
				end
		for (int t = 0; t < 4; t++) begin
			wr(SYNTH_CTRL_ADDR, {4'(t + 8), 4'h8});
			cyc(3);
			p = clock_output_pin_o;
			pulse(4'(1 << t));
			chk(16'(clock_output_pin_o), 16'(!p));
			// Status shows toggle state, drive enable and pin level
			rd(STATUS_ADDR, {5'h00, !p, 1'b1, !p});
			pulse(~4'(1 << t));
			chk(16'(clock_output_pin_o), 16'(!p));
		end
		wr(SYNTH_CTRL_ADDR, 8'h00);
		repeat (4) begin
			gpio_out <= 1'($random(seed));
			gpio_oe <= 1'($random(seed));
			clock_output_pin_i <= 1'($random(seed));
			cyc(3);
			chk({13'h0, gpio_in, clock_output_pin_oe, clock_output_pin_o},
				{13'h0, clock_output_pin_i, gpio_oe, gpio_out});
		end
		repeat (4) begin
			v = 8'($random(seed));
			wr(TRIM_ADDR, v);
			rd(TRIM_ADDR, v);
			chk(16'(slow_osc_trim_value), 16'(v));
		end
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		rd(TRIM_ADDR, TRIM_RST);
		cyc(3);
		give_verdict;
	end
endmodule
